/* File: src/ddp_pkg.sv */
package ddp_pkg;

  // ==========================================================================
  // Widths
  localparam int WORD_W = 16;
  localparam int MSB_LINE = 15;
  localparam int FIFO_AW = 2;
  localparam int BUF_DEPTH = 2;

  // ==========================================================================
  // Reset values
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [FIFO_AW:0] PTR_RST = 3'h0;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    DDP_MODE_PTR = 2'b01,
    DDP_MODE_SYNC = 2'b10
  } ddp_frame_mode_t;

  typedef struct packed {
    logic frame_start;
    logic parity_bit;
    logic [WORD_W-1:0] first_word;
    logic [WORD_W-1:0] second_word;
  } ddp_pair_t;

  localparam int PAIR_W = $bits(ddp_pair_t);

endpackage

/* File: src/ddp_buf2.sv */
`timescale 1ns/10ps
module ddp_buf2
  import ddp_pkg::*;
#(
  parameter int W = PAIR_W
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [1:0] count_q;
  logic [W-1:0] ent0_q;
  logic [W-1:0] ent1_q;
  logic push;
  logic pop;

  // ==========================================================================
  // Handshake
  assign in_ready = (count_q != 2'(BUF_DEPTH));
  assign out_valid = (count_q != 2'h0);
  assign out_data = ent0_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // ==========================================================================
  // Storage, head always in ent0 so the output is a flop
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      count_q <= 2'h0;
      ent0_q <= '0;
      ent1_q <= '0;
    end
    else if (push && pop)
    begin
      if (count_q == 2'h1)
        ent0_q <= in_data;
      else
      begin
        ent0_q <= ent1_q;
        ent1_q <= in_data;
      end
    end
    else if (push)
    begin
      if (count_q == 2'h0)
        ent0_q <= in_data;
      else
        ent1_q <= in_data;
      count_q <= count_q + 2'h1;
    end
    else if (pop)
    begin
      ent0_q <= ent1_q;
      count_q <= count_q - 2'h1;
    end
  end

endmodule

/* File: src/ddp_port.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - Bus words are taken on both edges of the source word clock.
// - Line 15 is the most significant bit by default, line 0 the least.
// - Reversal bit set flips bit order of each captured word before use.
// - Rising-edge marker sample restarts framing or serves as sync source.
// - Falling-edge marker sample is the block parity bit for the pair.
// - Asserted rising-edge marker marks the first word of a new frame in DDP_MODE_PTR only.
// - Each word clock period delivers two 16-bit words as one pair.
module ddp_port
  import ddp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic source_sync_word_clock,
  input wire logic [WORD_W-1:0] word_bus,
  input wire logic frame_marker_input,
  input wire logic bus_order_reverse,
  input wire ddp_frame_mode_t frame_mode,
  input wire logic parity_odd,
  input wire logic parity_error_clr,
  output logic out_valid,
  input wire logic out_ready,
  output ddp_pair_t out_pair,
  output logic sync_pulse,
  output logic parity_error,
  output logic overflow
);

  // ==========================================================================
  // Link domain reset, asserted at once, released on the link clock
  logic lrst_meta_q;
  logic lrst_q;

  always_ff @(posedge source_sync_word_clock or posedge rst)
  begin
    if (rst)
    begin
      lrst_meta_q <= 1'b1;
      lrst_q <= 1'b1;
    end
    else
    begin
      lrst_meta_q <= 1'b0;
      lrst_q <= lrst_meta_q;
    end
  end

  // ==========================================================================
  // Double-edge capture
  logic [WORD_W-1:0] rise_word_q;
  logic [WORD_W-1:0] fall_word_q;
  logic frame_rise_q;
  logic parity_fall_q;
  logic have_rise_q;

  always_ff @(negedge source_sync_word_clock or posedge rst)
  begin
    if (rst)
    begin
      fall_word_q <= WORD_RST;
      parity_fall_q <= 1'b0;
    end
    else
    begin
      fall_word_q <= word_bus;
      parity_fall_q <= frame_marker_input;
    end
  end

  always_ff @(posedge source_sync_word_clock or posedge rst)
  begin
    if (rst)
    begin
      rise_word_q <= WORD_RST;
      frame_rise_q <= 1'b0;
      have_rise_q <= 1'b0;
    end
    else
    begin
      rise_word_q <= word_bus;
      frame_rise_q <= frame_marker_input;
      have_rise_q <= !lrst_q;
    end
  end

  // ==========================================================================
  // Clock crossing FIFO, gray pointers; the host cannot be stalled
  logic [FIFO_AW:0] wbin_q;
  logic [FIFO_AW:0] wgray_q;
  logic [FIFO_AW:0] rbin_q;
  logic [FIFO_AW:0] rgray_q;
  logic [FIFO_AW:0] rgray_s1_q;
  logic [FIFO_AW:0] rgray_s2_q;
  logic [FIFO_AW:0] wgray_s1_q;
  logic [FIFO_AW:0] wgray_s2_q;
  logic [FIFO_AW:0] wbin_nx;
  logic [FIFO_AW:0] rbin_nx;
  ddp_pair_t mem_q [0:(1<<FIFO_AW)-1];
  ddp_pair_t wr_pair;
  logic full;
  logic wr_en;
  logic ovf_link_q;

  // Pair the previous rising word with the falling word that followed it
  assign wr_pair = '{frame_start: frame_rise_q, parity_bit: parity_fall_q,
                     first_word: rise_word_q, second_word: fall_word_q};
  assign full = (wgray_q == {~rgray_s2_q[FIFO_AW:FIFO_AW-1], rgray_s2_q[FIFO_AW-2:0]});
  assign wr_en = have_rise_q && !lrst_q && !full;
  assign wbin_nx = wbin_q + 3'h1;

  always_ff @(posedge source_sync_word_clock)
  begin
    if (wr_en)
      mem_q[wbin_q[FIFO_AW-1:0]] <= wr_pair;
  end

  always_ff @(posedge source_sync_word_clock or posedge rst)
  begin
    if (rst)
    begin
      wbin_q <= PTR_RST;
      wgray_q <= PTR_RST;
      rgray_s1_q <= PTR_RST;
      rgray_s2_q <= PTR_RST;
      ovf_link_q <= 1'b0;
    end
    else
    begin
      rgray_s1_q <= rgray_q;
      rgray_s2_q <= rgray_s1_q;
      if (wr_en)
      begin
        wbin_q <= wbin_nx;
        wgray_q <= wbin_nx ^ (wbin_nx >> 1);
      end
      // Lost pairs are remembered until reset
      if (have_rise_q && !lrst_q && full)
        ovf_link_q <= 1'b1;
    end
  end

  // ==========================================================================
  // System side read, reorder and parity
  logic ovf_s1_q;
  logic ovf_s2_q;
  logic empty;
  logic buf_ready;
  logic push;
  ddp_pair_t rd_pair;
  ddp_pair_t buf_in;
  logic parity_bad;
  logic parity_error_q;
  logic sync_pulse_q;

  function automatic logic [WORD_W-1:0] flip(input logic [WORD_W-1:0] w);
    logic [WORD_W-1:0] r;
    r = '0;
    for (int i = 0; i < WORD_W; i++)
      r[i] = w[MSB_LINE-i];
    return r;
  endfunction

  assign empty = (rgray_q == wgray_s2_q);
  assign rbin_nx = rbin_q + 3'h1;
  assign push = !empty && buf_ready;
  assign rd_pair = mem_q[rbin_q[FIFO_AW-1:0]];

  always_comb
  begin
    buf_in = rd_pair;
    if (bus_order_reverse)
    begin
      buf_in.first_word = flip(rd_pair.first_word);
      buf_in.second_word = flip(rd_pair.second_word);
    end
    // Sync mode hands the marker to sync_pulse instead of the data path
    if (frame_mode == DDP_MODE_SYNC)
      buf_in.frame_start = 1'b0;
  end

  // Parity covers both words as received, so bus order does not matter
  assign parity_bad = ((^{rd_pair.first_word, rd_pair.second_word}) ^ parity_odd)
                      != rd_pair.parity_bit;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rbin_q <= PTR_RST;
      rgray_q <= PTR_RST;
      wgray_s1_q <= PTR_RST;
      wgray_s2_q <= PTR_RST;
      ovf_s1_q <= 1'b0;
      ovf_s2_q <= 1'b0;
    end
    else
    begin
      wgray_s1_q <= wgray_q;
      wgray_s2_q <= wgray_s1_q;
      ovf_s1_q <= ovf_link_q;
      ovf_s2_q <= ovf_s1_q;
      if (push)
      begin
        rbin_q <= rbin_nx;
        rgray_q <= rbin_nx ^ (rbin_nx >> 1);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      parity_error_q <= 1'b0;
    else if (push && parity_bad)
      parity_error_q <= 1'b1;
    else if (parity_error_clr)
      parity_error_q <= 1'b0;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      sync_pulse_q <= 1'b0;
    else
      sync_pulse_q <= push && rd_pair.frame_start && (frame_mode == DDP_MODE_SYNC);
  end

  assign sync_pulse = sync_pulse_q;
  assign parity_error = parity_error_q;
  assign overflow = ovf_s2_q;

  ddp_buf2 #(
    .W(PAIR_W)
  ) u_buf (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(!empty),
    .in_ready(buf_ready),
    .in_data(buf_in),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_pair)
  );

  // ==========================================================================
  // Checks
  a_fall_word_capture:
  assert property (@(negedge source_sync_word_clock) disable iff (rst)
    1'b1 |=> fall_word_q == $past(word_bus))
  else $error("Falling-edge word not captured");

  a_pair_first_word:
  assert property (@(posedge source_sync_word_clock) disable iff (lrst_q)
    wr_en |-> wr_pair.first_word == $past(word_bus))
  else $error("Pair first word is not the previous rising-edge word");

  a_marker_rise_sample:
  assert property (@(posedge source_sync_word_clock) disable iff (lrst_q)
    wr_en |-> wr_pair.frame_start == $past(frame_marker_input))
  else $error("Frame start not taken from rising-edge marker");

  a_msb_order_kept:
  assert property (@(posedge sys_clk) disable iff (rst)
    push && !bus_order_reverse |-> buf_in.first_word[MSB_LINE] == rd_pair.first_word[MSB_LINE])
  else $error("Default bit order changed");

  a_reverse_order:
  assert property (@(posedge sys_clk) disable iff (rst)
    push && bus_order_reverse |-> buf_in.second_word[0] == rd_pair.second_word[MSB_LINE])
  else $error("Reversed bit order not applied");

  a_parity_flagged:
  assert property (@(posedge sys_clk) disable iff (rst)
    push && parity_bad |=> parity_error ##1 (parity_error || $past(parity_error_clr)))
  else $error("Parity mismatch not flagged");

  a_frame_sync_pulse:
  assert property (@(posedge sys_clk) disable iff (rst)
    push && rd_pair.frame_start && frame_mode == DDP_MODE_SYNC |=> sync_pulse ##1 !sync_pulse
    || $past(push))
  else $error("Frame start gave no sync pulse");

endmodule

/* File: dv/ddp_host_model.sv */
`timescale 1ns/10ps
// ==========================================================
// Host side of the link: clock stands still between frames
module ddp_host_model
  import ddp_pkg::*;
(
  output logic source_sync_word_clock,
  output logic [WORD_W-1:0] word_bus,
  output logic frame_marker_input
);
  initial
  begin
    source_sync_word_clock = 1'b0;
    word_bus = WORD_RST;
    frame_marker_input = 1'b0;
  end

  // One pair per period; bus and marker move together, mid-phase
  task automatic drive(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b,
                       input logic f, input logic p);
    word_bus = a;
    frame_marker_input = f;
    #31.25 source_sync_word_clock = 1'b1;
    #31.25 word_bus = b;
    frame_marker_input = p;
    #31.25 source_sync_word_clock = 1'b0;
    // Released lines show the inverse, never a stale valid value; it goes out
    // before the period ends so a following call never writes a line twice at once
    #15 word_bus = ~b;
    frame_marker_input = ~p;
    #16.25;
  endtask
endmodule

/* File: dv/ddp_lvds_sample_input_port_test.sv */
`timescale 1ns/10ps
module ddr_lvds_sample_input_port_test
  import ddp_pkg::*;
;
  logic sys_clk, rst, bus_order_reverse, parity_odd, parity_error_clr, out_ready;
  ddp_frame_mode_t frame_mode;
  wire logic source_sync_word_clock;
  wire logic frame_marker_input;
  wire logic [WORD_W-1:0] word_bus;
  logic out_valid, sync_pulse, parity_error, overflow;
  ddp_pair_t out_pair;
  ddp_pair_t expq[$];
  int failures, cmp_count, sync_cnt;

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  ddp_host_model u_host (
    .source_sync_word_clock(source_sync_word_clock),
    .word_bus(word_bus),
    .frame_marker_input(frame_marker_input)
  );

  ddp_port dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .source_sync_word_clock(source_sync_word_clock),
    .word_bus(word_bus),
    .frame_marker_input(frame_marker_input),
    .bus_order_reverse(bus_order_reverse),
    .frame_mode(frame_mode),
    .parity_odd(parity_odd),
    .parity_error_clr(parity_error_clr),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_pair(out_pair),
    .sync_pulse(sync_pulse),
    .parity_error(parity_error),
    .overflow(overflow)
  );

  always @(posedge sys_clk)
    if (sync_pulse === 1'b1)
      sync_cnt++;

  // ==========================================================
  // Helpers
  task automatic chk(input logic [PAIR_W-1:0] seen, input logic [PAIR_W-1:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [WORD_W-1:0] rev16(input logic [WORD_W-1:0] w);
    for (int i = 0; i < WORD_W; i++)
      rev16[i] = w[MSB_LINE-i];
  endfunction

  function automatic logic par(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b);
    return ~(^{a, b});
  endfunction

  task automatic snd(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b,
                     input logic f, input logic p);
    u_host.drive(a, b, f, p);
    expq.push_back('{f, p, a, b});
  endtask

  // Each pair is written only at the next rise, so a burst ends with two idle
  // pairs whose words survive reversal and whose parity is odd
  task automatic fin;
    snd(16'h0ff0, 16'h0ff0, 1'b0, 1'b1);
    snd(16'hf00f, 16'hf00f, 1'b0, 1'b1);
  endtask

  task automatic drain(input int n);
    ddp_pair_t e;
    int w;
    repeat (n)
    begin
      w = 0;
      @(negedge sys_clk);
      while (out_valid !== 1'b1 && w < 300)
      begin
        @(negedge sys_clk);
        w++;
      end
      chk(PAIR_W'(out_valid), PAIR_W'(1'b1));
      e = expq.pop_front();
      if (bus_order_reverse)
      begin
        e.first_word = rev16(e.first_word);
        e.second_word = rev16(e.second_word);
      end
      if (frame_mode == DDP_MODE_SYNC)
        e.frame_start = 1'b0;
      chk(out_pair, e);
      @(posedge sys_clk);
      out_ready <= 1'b1;
      @(posedge sys_clk);
      out_ready <= 1'b0;
    end
  endtask

  task automatic pe_is(input logic v);
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(PAIR_W'(parity_error), PAIR_W'(v));
  endtask

  task automatic clr;
    @(posedge sys_clk);
    parity_error_clr <= 1'b1;
    @(posedge sys_clk);
    parity_error_clr <= 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_basic;
    snd(16'h1234, 16'habcd, 1'b1, par(16'h1234, 16'habcd));
    snd(16'h8000, 16'h0001, 1'b0, par(16'h8000, 16'h0001));
    fin;
    drain(expq.size() - 1);
    pe_is(1'b0);
    $display("test basic done");
  endtask

  task automatic t_rev;
    @(posedge sys_clk);
    bus_order_reverse <= 1'b1;
    snd(16'h0001, 16'hc000, 1'b1, par(16'h0001, 16'hc000));
    fin;
    drain(expq.size() - 1);
    @(posedge sys_clk);
    bus_order_reverse <= 1'b0;
    $display("test reverse done");
  endtask

  task automatic t_sync;
    @(posedge sys_clk);
    frame_mode <= DDP_MODE_SYNC;
    sync_cnt = 0;
    snd(16'h00ff, 16'hff00, 1'b1, par(16'h00ff, 16'hff00));
    fin;
    drain(expq.size() - 1);
    chk(PAIR_W'(sync_cnt), PAIR_W'(1));
    @(posedge sys_clk);
    frame_mode <= DDP_MODE_PTR;
    $display("test sync done");
  endtask

  // Even parity: the odd idle pair and a bad pair must flag, a good one not
  task automatic t_par;
    @(posedge sys_clk);
    parity_odd <= 1'b0;
    snd(16'h0003, 16'h0000, 1'b0, 1'b0);
    drain(1);
    pe_is(1'b1);
    clr;
    snd(16'h0001, 16'h0000, 1'b0, 1'b0);
    drain(1);
    pe_is(1'b0);
    fin;
    drain(2);
    pe_is(1'b1);
    @(posedge sys_clk);
    parity_odd <= 1'b1;
    clr;
    $display("test parity done");
  endtask

  // Receiver stalls: six pairs fit, the two newest are lost
  task automatic t_ovf;
    for (int i = 1; i < 7; i++)
      snd(i[15:0], ~i[15:0], 1'b0, par(i[15:0], ~i[15:0]));
    fin;
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(PAIR_W'(overflow), PAIR_W'(1'b1));
    drain(6);
    expq.delete(0);
    expq.delete(0);
    $display("test overflow done");
  endtask

  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #200000;
    failures++;
    close_out;
  end

  initial
  begin
    rst = 1'b1;
    bus_order_reverse = 1'b0;
    frame_mode = DDP_MODE_PTR;
    parity_odd = 1'b1;
    parity_error_clr = 1'b0;
    out_ready = 1'b0;
    failures = 0;
    cmp_count = 0;
    sync_cnt = 0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    // Link side writes nothing before its fourth rise, so two idle pairs lead
    u_host.drive(16'hf00f, 16'hf00f, 1'b0, 1'b1);
    u_host.drive(16'hf00f, 16'hf00f, 1'b0, 1'b1);
    t_basic;
    t_rev;
    t_sync;
    t_par;
    t_ovf;
    close_out;
  end
endmodule
